// File: pkg/fsp_pkg.sv
// constants and types shared by the flash self-program sequencer and its core side
// Overview of operation
// - erase code then store within four clocks
// - erase takes only the page field
// - core stalls for the whole erase
// - load code then store writes one word
// - buffer clears after write, clear bit, reset
// - software never loads one word twice
// - eeprom write during loading discards buffer
// - write code then store programs buffered page
// - software zeroes pointer bits outside page
// - core stalls for the whole page write
// - software uses same page for erase, write
// - pointer splits into word and page fields
// - byte reads use the byte select bit
// - eeprom busy blocks commands and fuse reads
// - software polls eeprom busy before commanding
// - buffer words load in any order
// - buffer survives erase, loads before or after
// - software saves unchanged words before erasing
// - store enable clears on store or timeout
// - store enable stays set while busy
// - undefined control codes have no effect
package fsp_pkg;
   localparam int ADDR_W = 16;
   localparam int WORD_W = 16;
   localparam int CTRL_W = 8;
   localparam int CMD_W = 5;
   localparam logic [CMD_W-1:0] CMD_LOAD = 5'h01;
   localparam logic [CMD_W-1:0] CMD_ERASE = 5'h03;
   localparam logic [CMD_W-1:0] CMD_WRITE = 5'h05;
   localparam logic [CMD_W-1:0] CMD_FUSE = 5'h09;
   localparam logic [CMD_W-1:0] CMD_CLEAR = 5'h11;
   localparam logic [CMD_W-1:0] CMD_NONE = 5'h00;
   localparam int STORE_WIN = 4;
   localparam int FUSE_WIN = 3;
   localparam int WIN_W = 3;
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_TIME_NS = 3700000;
   localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;
   localparam logic [ADDR_W-1:0] FUSE_LO_PTR = 16'h0000;
   localparam logic [ADDR_W-1:0] LOCK_PTR = 16'h0001;
   localparam logic [ADDR_W-1:0] FUSE_HI_PTR = 16'h0003;
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam logic [APB_AW-1:0] OFS_ADDR = 8'h00;
   localparam logic [APB_AW-1:0] OFS_DATA = 8'h04;
   localparam logic [APB_AW-1:0] OFS_CTRL = 8'h08;
   localparam logic [APB_AW-1:0] OFS_STORE = 8'h0C;
   localparam logic [APB_AW-1:0] OFS_LOAD = 8'h10;
   localparam logic [APB_AW-1:0] OFS_STATUS = 8'h14;
   localparam int ST_STALL = 0;
   localparam int ST_EEBUSY = 1;
   localparam int ST_LOADED = 2;
   typedef enum logic [1:0] {
      FSP_IDLE = 2'b00,
      FSP_ARMED = 2'b01,
      FSP_BUSY = 2'b11
   } fsp_state_e;
endpackage

// File: pkg/fsp_if.sv
// link between the processor core side and the flash sequencer
interface fsp_if (
   input logic pclk,
   input logic presetn
);
   logic ctrl_wr;
   logic [fsp_pkg::CTRL_W-1:0] ctrl_wdata;
   logic [fsp_pkg::CTRL_W-1:0] ctrl_rdata;
   logic store_req;
   logic load_req;
   logic [fsp_pkg::ADDR_W-1:0] addr_ptr;
   logic [fsp_pkg::WORD_W-1:0] data_word;
   logic eeprom_busy;
   logic core_stall;
   logic load_valid;
   logic [7:0] load_data;
   modport core (
      input pclk,
      input presetn,
      output ctrl_wr,
      output ctrl_wdata,
      input ctrl_rdata,
      output store_req,
      output load_req,
      output addr_ptr,
      output data_word,
      output eeprom_busy,
      input core_stall,
      input load_valid,
      input load_data
   );
   modport flash (
      input pclk,
      input presetn,
      input ctrl_wr,
      input ctrl_wdata,
      output ctrl_rdata,
      input store_req,
      input load_req,
      input addr_ptr,
      input data_word,
      input eeprom_busy,
      output core_stall,
      output load_valid,
      output load_data
   );
endinterface

// File: hw/fsp_page_buf.sv
// temporary page buffer, one word per entry, erased value after clear
module fsp_page_buf #(
   parameter int WORDS = 32,
   parameter int IW = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic wr_en,
   input wire logic [IW-1:0] wr_idx,
   input wire logic [fsp_pkg::WORD_W-1:0] wr_data,
   input wire logic [IW-1:0] rd_idx,
   output logic [fsp_pkg::WORD_W-1:0] rd_data,
   output logic dirty
);
   import fsp_pkg::*;
   logic [WORD_W-1:0] mem_r [WORDS];
   logic dirty_r;

   if (WORDS < 2 || (1 << IW) != WORDS) begin : g_chk
      $error("page buffer depth must be a power of two matching IW");
   end

   // any index may be written at any time, so entries are independent
   for (genvar i = 0; i < WORDS; i++) begin : g_word
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mem_r[i] <= ERASED_WORD;
         end else if (clear) begin
            mem_r[i] <= ERASED_WORD;
         end else if (wr_en && wr_idx == IW'(i)) begin
            mem_r[i] <= wr_data;
         end
      end
   end

   // a load in the clearing cycle still sets dirty, though the clear erases the word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dirty_r <= 1'b0;
      end else if (wr_en) begin
         dirty_r <= 1'b1;
      end else if (clear) begin
         dirty_r <= 1'b0;
      end
   end

   assign rd_data = mem_r[rd_idx];
   assign dirty = dirty_r;
endmodule

// File: hw/fsp_flash_seq.sv
// flash self-program sequencer: control register, page buffer, erase and write
module fsp_flash_seq #(
   parameter int PAGE_WORDS = 32,
   parameter int PAGES = 64,
   parameter int PROG_CYCLES = fsp_pkg::PROG_CYCLES,
   parameter logic [7:0] FUSE_LO_VAL = 8'h5A, // arbitrary
   parameter logic [7:0] FUSE_HI_VAL = 8'hC3, // arbitrary
   parameter logic [7:0] LOCK_VAL = 8'h03 // arbitrary
) (
   fsp_if.flash bus
);
   import fsp_pkg::*;
   localparam int WB = $clog2(PAGE_WORDS);
   localparam int PB = $clog2(PAGES);
   localparam int FA = WB + PB;
   localparam int CW = $clog2(PROG_CYCLES + 1);

   if ((1 << WB) != PAGE_WORDS || (1 << PB) != PAGES || FA + 1 > ADDR_W
       || PROG_CYCLES < PAGE_WORDS) begin : g_chk
      $error("flash geometry or program time not supported");
   end

   fsp_state_e state_r;
   logic [CMD_W-1:0] cmd_r;
   logic [WIN_W-1:0] win_r;
   logic [CW-1:0] cnt_r;
   logic [PB-1:0] op_page_r;
   logic op_write_r;
   logic load_valid_r;
   logic [7:0] load_data_r;
   logic [WORD_W-1:0] flash_mem [PAGES * PAGE_WORDS];

   logic [CMD_W-1:0] code;
   logic [WB-1:0] word_idx;
   logic [PB-1:0] page_idx;
   logic [FA-1:0] read_idx;
   logic code_ok;
   logic ctrl_ok;
   logic store_go;
   logic fuse_go;
   logic last_cycle;
   logic buf_clear;
   logic buf_dirty;
   logic [WORD_W-1:0] buf_rd;
   logic [WORD_W-1:0] rd_word;
   logic [7:0] fuse_byte;

   assign code = bus.ctrl_wdata[CMD_W-1:0];
   assign word_idx = bus.addr_ptr[WB:1];
   assign page_idx = bus.addr_ptr[FA:WB+1];
   assign read_idx = bus.addr_ptr[FA:1];

   // only the five defined combinations are taken
   assign code_ok = (code == CMD_LOAD) || (code == CMD_ERASE) || (code == CMD_WRITE)
                    || (code == CMD_FUSE) || (code == CMD_CLEAR);

   // while armed, a store in the same cycle as a control write wins and the control write is dropped
   assign ctrl_ok = bus.ctrl_wr && code_ok && !bus.eeprom_busy
                    && state_r != FSP_BUSY
                    && !(state_r == FSP_ARMED && bus.store_req);

   assign store_go = bus.store_req && state_r == FSP_ARMED
                     && !bus.eeprom_busy;

   assign fuse_go = bus.load_req && state_r == FSP_ARMED && cmd_r == CMD_FUSE
                    && win_r < WIN_W'(FUSE_WIN) && !bus.eeprom_busy;

   assign last_cycle = state_r == FSP_BUSY && cnt_r == CW'(PROG_CYCLES - 1);

   assign buf_clear = (last_cycle && op_write_r)
                      || (ctrl_ok && code == CMD_CLEAR)
                      || (bus.eeprom_busy && buf_dirty);

   fsp_page_buf #(
      .WORDS(PAGE_WORDS),
      .IW(WB)
   ) u_buf (
      .pclk(bus.pclk),
      .presetn(bus.presetn),
      .clear(buf_clear),
      .wr_en(store_go && cmd_r == CMD_LOAD),
      .wr_idx(word_idx),
      .wr_data(bus.data_word),
      .rd_idx(cnt_r[WB-1:0]),
      .rd_data(buf_rd),
      .dirty(buf_dirty)
   );

   // sequencing: armed window, then erase or write runs to its timed end
   always_ff @(posedge bus.pclk or negedge bus.presetn) begin
      if (!bus.presetn) begin
         state_r <= FSP_IDLE;
         cmd_r <= CMD_NONE;
         win_r <= '0;
      end else begin
         unique case (state_r)
            FSP_IDLE: begin
               if (ctrl_ok) begin
                  state_r <= FSP_ARMED;
                  cmd_r <= code;
                  win_r <= '0;
               end
            end
            FSP_ARMED: begin
               if (store_go && (cmd_r == CMD_ERASE || cmd_r == CMD_WRITE)) begin
                  state_r <= FSP_BUSY;
               end else if (store_go || fuse_go) begin
                  state_r <= FSP_IDLE;
                  cmd_r <= CMD_NONE;
               end else if (ctrl_ok) begin
                  cmd_r <= code;
                  win_r <= '0;
               end else if (win_r == WIN_W'(STORE_WIN - 1)) begin
                  state_r <= FSP_IDLE;
                  cmd_r <= CMD_NONE;
               end else begin
                  win_r <= win_r + WIN_W'(1);
               end
            end
            FSP_BUSY: begin
               if (last_cycle) begin
                  state_r <= FSP_IDLE;
                  cmd_r <= CMD_NONE;
               end
            end
         endcase
      end
   end

   // the page is latched at the store so later pointer changes cannot move it
   always_ff @(posedge bus.pclk or negedge bus.presetn) begin
      if (!bus.presetn) begin
         op_page_r <= '0;
         op_write_r <= 1'b0;
      end else if (store_go) begin
         op_page_r <= page_idx;
         op_write_r <= cmd_r == CMD_WRITE;
      end
   end

   always_ff @(posedge bus.pclk or negedge bus.presetn) begin
      if (!bus.presetn) begin
         cnt_r <= '0;
      end else if (state_r == FSP_BUSY) begin
         cnt_r <= cnt_r + CW'(1);
      end else begin
         cnt_r <= '0;
      end
   end

   // the page is touched in the first cycles; the rest is program time
   always_ff @(posedge bus.pclk) begin
      if (state_r == FSP_BUSY && cnt_r < CW'(PAGE_WORDS)) begin
         if (op_write_r) begin
            flash_mem[{op_page_r, cnt_r[WB-1:0]}] <= buf_rd;
         end else begin
            flash_mem[{op_page_r, cnt_r[WB-1:0]}] <= ERASED_WORD;
         end
      end
   end

   assign rd_word = flash_mem[read_idx];

   always_comb begin
      fuse_byte = FUSE_LO_VAL;
      if (bus.addr_ptr == LOCK_PTR) begin
         fuse_byte = LOCK_VAL;
      end else if (bus.addr_ptr == FUSE_HI_PTR) begin
         fuse_byte = FUSE_HI_VAL;
      end else if (bus.addr_ptr == FUSE_LO_PTR) begin
         fuse_byte = FUSE_LO_VAL;
      end
   end

   // blocked fuse reads fall back to an ordinary program byte read
   always_ff @(posedge bus.pclk or negedge bus.presetn) begin
      if (!bus.presetn) begin
         load_valid_r <= 1'b0;
         load_data_r <= '0;
      end else begin
         load_valid_r <= bus.load_req && state_r != FSP_BUSY;
         if (bus.load_req && state_r != FSP_BUSY) begin
            if (fuse_go) begin
               load_data_r <= fuse_byte;
            end else if (bus.addr_ptr[0]) begin
               load_data_r <= rd_word[WORD_W-1:8];
            end else begin
               load_data_r <= rd_word[7:0];
            end
         end
      end
   end

   assign bus.core_stall = state_r == FSP_BUSY;
   assign bus.ctrl_rdata = {{(CTRL_W - CMD_W){1'b0}}, cmd_r};
   assign bus.load_valid = load_valid_r;
   assign bus.load_data = load_data_r;
endmodule

// File: hw/fsp_core_side.sv
// processor core side: apb registers that issue control writes, stores and loads
module fsp_core_side (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fsp_pkg::APB_AW-1:0] paddr,
   input wire logic [fsp_pkg::APB_DW-1:0] pwdata,
   output logic [fsp_pkg::APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   fsp_if.core bus
);
   import fsp_pkg::*;
   logic [ADDR_W-1:0] addr_r;
   logic [WORD_W-1:0] data_r;
   logic ctrl_wr_r;
   logic [CTRL_W-1:0] ctrl_wdata_r;
   logic store_r;
   logic load_r;
   logic ee_busy_r;
   logic loaded_r;
   logic [7:0] load_byte_r;
   logic [APB_DW-1:0] prdata_r;
   logic [APB_DW-1:0] rd_mux;
   logic mapped;
   logic wr_acc;

   assign mapped = paddr == OFS_ADDR || paddr == OFS_DATA || paddr == OFS_CTRL
                   || paddr == OFS_STORE || paddr == OFS_LOAD || paddr == OFS_STATUS;
   // a stalled core cannot finish any access until the flash operation ends
   assign pready = !bus.core_stall;
   assign pslverr = psel && penable && !mapped;
   assign wr_acc = psel && penable && pready && pwrite && mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r <= '0;
         data_r <= '0;
         ctrl_wdata_r <= '0;
         ee_busy_r <= 1'b0;
      end else if (wr_acc) begin
         if (paddr == OFS_ADDR) begin
            addr_r <= pwdata[ADDR_W-1:0];
         end
         if (paddr == OFS_DATA) begin
            data_r <= pwdata[WORD_W-1:0];
         end
         if (paddr == OFS_CTRL) begin
            ctrl_wdata_r <= pwdata[CTRL_W-1:0];
         end
         if (paddr == OFS_STATUS) begin
            ee_busy_r <= pwdata[ST_EEBUSY];
         end
      end
   end

   // one-cycle requests toward the sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_wr_r <= 1'b0;
         store_r <= 1'b0;
         load_r <= 1'b0;
      end else begin
         ctrl_wr_r <= wr_acc && paddr == OFS_CTRL;
         store_r <= wr_acc && paddr == OFS_STORE;
         load_r <= wr_acc && paddr == OFS_LOAD;
      end
   end

   // a fresh answer sets the flag even if a read clears it in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded_r <= 1'b0;
         load_byte_r <= '0;
      end else if (bus.load_valid) begin
         loaded_r <= 1'b1;
         load_byte_r <= bus.load_data;
      end else if (psel && penable && pready && !pwrite && paddr == OFS_LOAD) begin
         loaded_r <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = '0;
      unique case (paddr)
         OFS_ADDR: rd_mux[ADDR_W-1:0] = addr_r;
         OFS_DATA: rd_mux[WORD_W-1:0] = data_r;
         OFS_CTRL: rd_mux[CTRL_W-1:0] = bus.ctrl_rdata;
         OFS_LOAD: rd_mux[7:0] = load_byte_r;
         OFS_STATUS: begin
            rd_mux[ST_STALL] = bus.core_stall;
            rd_mux[ST_EEBUSY] = ee_busy_r;
            rd_mux[ST_LOADED] = loaded_r;
         end
         default: rd_mux = '0;
      endcase
   end

   // read data is refreshed every cycle of the transfer until it completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (psel && !(penable && pready)) begin
         prdata_r <= rd_mux;
      end
   end

   assign prdata = prdata_r;
   assign bus.ctrl_wr = ctrl_wr_r;
   assign bus.ctrl_wdata = ctrl_wdata_r;
   assign bus.store_req = store_r;
   assign bus.load_req = load_r;
   assign bus.addr_ptr = addr_r;
   assign bus.data_word = data_r;
   assign bus.eeprom_busy = ee_busy_r;
endmodule

// File: test/fsp_properties.sv
// concurrent checks on the link between the core side and the flash sequencer
module fsp_properties #(
   parameter int PROG_CYCLES = 40
) (
   input logic pclk,
   input logic presetn,
   input logic ctrl_wr,
   input logic [fsp_pkg::CTRL_W-1:0] ctrl_wdata,
   input logic [fsp_pkg::CTRL_W-1:0] ctrl_rdata,
   input logic store_req,
   input logic load_req,
   input logic [fsp_pkg::ADDR_W-1:0] addr_ptr,
   input logic [fsp_pkg::WORD_W-1:0] data_word,
   input logic eeprom_busy,
   input logic core_stall,
   input logic load_valid,
   input logic [7:0] load_data
);
   import fsp_pkg::*;
   logic [31:0] stall_cnt_r;
   logic code_ok;
   logic idle;
   assign code_ok = ctrl_wdata[4:0] inside {CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_FUSE, CMD_CLEAR};
   assign idle = !core_stall && !eeprom_busy;
   // counts stall length; a unrolled repetition would be far too long
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_cnt_r <= '0;
      end else if (core_stall) begin
         stall_cnt_r <= stall_cnt_r + 32'h1;
      end else begin
         stall_cnt_r <= '0;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_cmd_taken;
      ctrl_wr && code_ok && idle && !store_req;
   endsequence
   sequence s_prog_store(logic [4:0] code);
      store_req && !ctrl_wr && idle && ctrl_rdata[4:0] == code;
   endsequence
   AST_ERASE_GO: assert property (s_prog_store(CMD_ERASE) |=> core_stall)
      else $error("erase store did not stall the core");
   AST_WRITE_GO: assert property (s_prog_store(CMD_WRITE) |=> core_stall)
      else $error("write store did not stall the core");
   AST_STALL_LEN: assert property ($fell(core_stall) |-> stall_cnt_r == PROG_CYCLES)
      else $error("stall length wrong");
   AST_BUSY_EN: assert property (core_stall |-> ctrl_rdata[0])
      else $error("store enable low while busy");
   AST_RESUME: assert property ($fell(core_stall) |-> ctrl_rdata == 8'h00)
      else $error("command not cleared at end of operation");
   AST_SHOW: assert property (s_cmd_taken |=> ctrl_rdata == {3'h0, $past(ctrl_wdata[4:0])})
      else $error("accepted command not shown");
   AST_TIMEOUT: assert property (s_cmd_taken ##1 (!store_req && !ctrl_wr && !load_req) [*4]
         |=> ctrl_rdata == 8'h00)
      else $error("command not cancelled after window");
   AST_LOAD_DONE: assert property (s_prog_store(CMD_LOAD) |=> ctrl_rdata == 8'h00 && !core_stall)
      else $error("load store did not complete");
   AST_BAD_CODE: assert property (ctrl_wr && !code_ok && ctrl_rdata == 8'h00 && !core_stall
         |=> ctrl_rdata == 8'h00)
      else $error("undefined code had an effect");
   AST_EE_BLOCK: assert property (ctrl_wr && eeprom_busy && ctrl_rdata == 8'h00
         |=> ctrl_rdata == 8'h00)
      else $error("command taken during eeprom write");
   AST_LOAD_ANS: assert property (load_req && !core_stall |=> load_valid)
      else $error("byte load not answered");
endmodule

// File: test/test_flash_self_program_sequencer.sv
// self-checking bench: apb sequences drive the core side against the flash sequencer
module test_flash_self_program_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   import fsp_pkg::*;
   localparam int PROG = 40;
   localparam logic [7:0] FLO = 8'h6B; // arbitrary
   localparam logic [7:0] FHI = 8'h9D; // arbitrary
   localparam logic [7:0] LCK = 8'h02; // arbitrary
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [APB_AW-1:0] paddr;
   logic [APB_DW-1:0] pwdata;
   logic [APB_DW-1:0] prdata;
   logic pready;
   logic pslverr;
   logic err_q;
   logic [31:0] q;
   int waited;
   int errors;
   int samples_checked;
   logic [4:0] codes [5] = '{CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_FUSE, CMD_CLEAR};
   logic [4:0] bad [4] = '{5'h02, 5'h07, 5'h13, 5'h1F};
   fsp_if link (.pclk(pclk), .presetn(presetn));
   fsp_core_side u_fsp_core_side (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link.core));
   // short programming time keeps the run small
   fsp_flash_seq #(.PROG_CYCLES(PROG), .FUSE_LO_VAL(FLO), .FUSE_HI_VAL(FHI),
      .LOCK_VAL(LCK)) u_fsp_flash_seq (.bus(link.flash));
   fsp_properties #(.PROG_CYCLES(PROG)) u_fsp_properties (.pclk(link.pclk),
      .presetn(link.presetn), .ctrl_wr(link.ctrl_wr), .ctrl_wdata(link.ctrl_wdata),
      .ctrl_rdata(link.ctrl_rdata), .store_req(link.store_req), .load_req(link.load_req),
      .addr_ptr(link.addr_ptr), .data_word(link.data_word), .eeprom_busy(link.eeprom_busy),
      .core_stall(link.core_stall), .load_valid(link.load_valid), .load_data(link.load_data));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // keep leaves psel high so the next setup follows at once
   task automatic apb(input logic wr, input logic keep, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      waited = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && waited < 200) begin
         waited++;
         @(posedge pclk);
      end
      if (pready !== 1'b1) begin
         errors++;
         close_out();
      end
      q = prdata;
      err_q = pslverr;
      penable <= 1'b0;
      if (!keep) begin
         psel <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, 1'b0, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, 1'b0, a, 32'h0);
      check(q, exp);
   endtask
   // control write and store back to back, as the core would issue them
   task automatic op(input logic [4:0] code, input logic [15:0] ad, input logic [15:0] dw);
      wr(OFS_ADDR, {16'h0, ad});
      wr(OFS_DATA, {16'h0, dw});
      apb(1'b1, 1'b1, OFS_CTRL, {27'h0, code});
      apb(1'b1, 1'b0, OFS_STORE, 32'h0);
   endtask
   task automatic rbyte(input logic [15:0] ad, input logic [7:0] exp);
      wr(OFS_ADDR, {16'h0, ad});
      wr(OFS_LOAD, 32'h0);
      repeat (2) @(posedge pclk);
      rdc(OFS_LOAD, {24'h0, exp});
   endtask
   // fuse code and load back to back, inside the three-cycle window
   task automatic rfuse(input logic [15:0] ad, input logic [7:0] exp);
      wr(OFS_ADDR, {16'h0, ad});
      apb(1'b1, 1'b1, OFS_CTRL, {27'h0, CMD_FUSE});
      apb(1'b1, 1'b0, OFS_LOAD, 32'h0);
      repeat (2) @(posedge pclk);
      rdc(OFS_LOAD, {24'h0, exp});
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      errors = 0;
      samples_checked = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(OFS_CTRL, 32'h0);
      rdc(OFS_STATUS, 32'h0);
      rdc(8'h20, 32'h0);
      check({31'h0, err_q}, 32'h1);
      foreach (codes[i]) begin
         wr(OFS_CTRL, {27'h0, codes[i]});
         rdc(OFS_CTRL, {27'h0, codes[i]});
         repeat (6) @(posedge pclk);
         rdc(OFS_CTRL, 32'h0);
      end
      foreach (bad[i]) begin
         wr(OFS_CTRL, {27'h0, bad[i]});
         rdc(OFS_CTRL, 32'h0);
      end
      $display("test codes done");
      op(CMD_ERASE, 16'hF0FF, 16'h1234);
      rdc(OFS_STATUS, 32'h1);
      check(waited, PROG - 1);
      rdc(OFS_CTRL, 32'h0);
      rbyte(16'h00C0, 8'hFF);
      rbyte(16'h00FF, 8'hFF);
      $display("test erase done");
      rfuse(16'h0001, LCK);
      rfuse(16'h0003, FHI);
      rfuse(16'h0000, FLO);
      rdc(OFS_CTRL, 32'h0);
      wr(OFS_STATUS, 32'h2);
      rfuse(16'h00C1, 8'hFF);
      wr(OFS_STATUS, 32'h0);
      $display("test fuse read done");
      op(CMD_LOAD, 16'h01CA, 16'hA55A);
      op(CMD_LOAD, 16'h01C5, 16'h1234);
      rdc(OFS_CTRL, 32'h0);
      op(CMD_ERASE, 16'h01C0, 16'h0000);
      op(CMD_WRITE, 16'h01C0, 16'hFFFF);
      rdc(OFS_STATUS, 32'h1);
      check(waited, PROG - 1);
      rbyte(16'h01CA, 8'h5A);
      rbyte(16'h01CB, 8'hA5);
      rbyte(16'h01C4, 8'h34);
      rbyte(16'h01C5, 8'h12);
      rbyte(16'h01C6, 8'hFF);
      $display("test page write done");
      op(CMD_LOAD, 16'h0240, 16'hBEEF);
      op(CMD_CLEAR, 16'h0240, 16'h0000);
      op(CMD_LOAD, 16'h0242, 16'hCAFE);
      wr(OFS_STATUS, 32'h2);
      rdc(OFS_STATUS, 32'h2);
      wr(OFS_CTRL, {27'h0, CMD_LOAD});
      rdc(OFS_CTRL, 32'h0);
      wr(OFS_STATUS, 32'h0);
      rdc(OFS_STATUS, 32'h0);
      op(CMD_LOAD, 16'h0244, 16'h0102);
      op(CMD_ERASE, 16'h0240, 16'h0000);
      op(CMD_WRITE, 16'h0240, 16'h0000);
      rbyte(16'h0240, 8'hFF);
      rbyte(16'h0242, 8'hFF);
      rbyte(16'h0244, 8'h02);
      rbyte(16'h024B, 8'hFF);
      $display("test buffer clear done");
      close_out();
   end
endmodule
